// File: rtl/ddrp_fifo.sv
// ddrp_fifo: synchronous first-word-fall-through fifo with valid/ready on both sides.
// assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module ddrp_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  // ===========================================================================
  // elaboration check: the pointer wrap only works for a power-of-two depth
  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH)
    begin : g_bad_depth
      $error("ddrp_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  // ===========================================================================
  // storage and pointers; the extra pointer bit tells full from empty
  logic [WIDTH-1:0] mem_q [DEPTH];   // entries
  logic [PW:0]      wr_ptr_q;        // fill pointer
  logic [PW:0]      rd_ptr_q;        // drain pointer
  logic             push;            // accepted write
  logic             pop;             // accepted read

  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign in_ready  = (wr_ptr_q[PW] == rd_ptr_q[PW]) || (wr_ptr_q[PW-1:0] != rd_ptr_q[PW-1:0]);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q[PW-1:0]];

  // pointer update
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // entry write, no reset needed on data
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_q[wr_ptr_q[PW-1:0]] <= in_data;
  end

endmodule

// File: rtl/ddrp_pkg.sv
// ddrp_pkg: shared constants of the double-data-rate burst-of-four sram port.
// assumes clk_sys runs at twice the memory clock rate, one sys cycle per half cycle.
package ddrp_pkg;

  // ===========================================================================
  // organisation
  localparam int DATA_W   = 18;  // 18-bit organisation
  localparam int LANE_W   = 9;   // one byte lane with its parity bit
  localparam int LANES    = 2;   // lane 0 = bits 0-8, lane 1 = bits 9-17
  localparam int ADDR_W   = 20;  // 1M words
  localparam int BURST    = 4;   // fixed burst length
  localparam int BURST_W  = 2;   // burst counter width, wraps modulo four

  // ===========================================================================
  // timing, counted in half cycles of the memory clock (one clk_sys each)
  localparam real CLK_SYS_NS     = 25.0;  // 40 MHz
  localparam int  RD_FIRST_HALF  = 3;     // first read beat at t+1.5
  localparam int  WR_FIRST_HALF  = 8;     // first write beat at t+4.0
  // stage of the command pipe that launches or captures beat 0
  localparam int  RD_STAGE0      = RD_FIRST_HALF - 1;
  localparam int  WR_STAGE0      = WR_FIRST_HALF - 1;
  localparam int  PIPE_DEPTH     = WR_STAGE0 + BURST;

  // ===========================================================================
  // buffering and reset values
  localparam int           WQ_DEPTH   = 16;
  localparam logic [DATA_W-1:0] DQ_RST = 18'h00000;
  localparam logic         PHASE_RISE = 1'b0;  // k rising slot; 1 = k# rising slot

endpackage

// File: rtl/ddrp_port.sv
// ddrp_port: command, burst and data phases of a ddr burst-of-four common-io sram.
// assumes the master drives pins synchronous to clk_sys; each clk_sys is one half
// of the memory clock, and k_run low models a stopped input clock.
//
// Functional notes
// R1: burst addresses are loaded address plus 0..3
// R2: only the two low bits count, modulo four
// R3: load select low at k rise takes command
// R4: load select high is idle, bus stays released
// R5: the sampling k rise defines cycle t
// R6: read beats driven at t+1.5, 2.0, 2.5, 3.0
// R7: write beats captured at t+4.0, 4.5, 5.0, 5.5
// R8: per-beat lane selects write lanes, both high abort
// R9: stopped clock holds pins; master drains bursts first
// R10: tied output clocks time reads from input clock
// R11: master spaces loads at least two k cycles
`timescale 1ns/1ps
module ddrp_port #(
  parameter int ADDR_W   = ddrp_pkg::ADDR_W,
  parameter int WQ_DEPTH = ddrp_pkg::WQ_DEPTH
) (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  // clock pair status
  input  wire logic                        k_run,
  input  wire logic                        oclk_run,
  input  wire logic                        single_clk_mode,
  // command
  input  wire logic                        load_select_n,
  input  wire logic                        rw_sel,
  input  wire logic [ADDR_W-1:0]           addr,
  // byte lanes
  input  wire logic                        lane0_write_sel_n,
  input  wire logic                        lane1_write_sel_n,
  // common data bus
  input  wire logic [ddrp_pkg::DATA_W-1:0] dq_i,
  output logic [ddrp_pkg::DATA_W-1:0]      dq_o,
  output logic                             dq_oe,
  // status
  output logic                             k_phase,
  output logic                             wr_drop
);

  localparam int DW  = ddrp_pkg::DATA_W;
  localparam int LW  = ddrp_pkg::LANE_W;
  localparam int NL  = ddrp_pkg::LANES;
  localparam int BW  = ddrp_pkg::BURST_W;
  localparam int PD  = ddrp_pkg::PIPE_DEPTH;
  localparam int RS0 = ddrp_pkg::RD_STAGE0;
  localparam int WS0 = ddrp_pkg::WR_STAGE0;
  localparam int QW  = ADDR_W + DW + NL;   // queued write: address, data, lane enables

  // ===========================================================================
  // elaboration check: the burst counter needs two address bits
  generate
    if (ADDR_W < BW || ADDR_W > 24)
    begin : g_bad_addr_w
      $error("ddrp_port: ADDR_W must lie between 2 and 24");
    end
  endgenerate

  // ===========================================================================
  // half-cycle phase; frozen while the input clock is stopped
  logic phase_q;     // 0 = k rising slot, 1 = k# rising slot
  logic take_cmd;    // command sampled this edge

  assign take_cmd = k_run && (phase_q == ddrp_pkg::PHASE_RISE) && !load_select_n;  // R3 R5

  // phase divider
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      phase_q <= ddrp_pkg::PHASE_RISE;
    else if (k_run)                                     // R9
      phase_q <= ~phase_q;
  end

  // ===========================================================================
  // command pipe: one stage per half cycle after t, holds valid, read flag, address
  logic              pv_q [PD];   // stage holds a command
  logic              pr_q [PD];   // stage holds a read
  logic [ADDR_W-1:0] pa_q [PD];   // loaded address of that command

  // stage 0 loads; an idle cycle loads an empty stage
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pv_q[0] <= 1'b0;
      pr_q[0] <= 1'b0;
      pa_q[0] <= '0;
    end
    else if (k_run)                                     // R9
    begin
      pv_q[0] <= take_cmd;                              // R4
      pr_q[0] <= rw_sel;
      pa_q[0] <= addr;
    end
  end

  // later stages shift along with the input clock
  genvar gs;
  generate
    for (gs = 1; gs < PD; gs++)
    begin : g_pipe
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          pv_q[gs] <= 1'b0;
          pr_q[gs] <= 1'b0;
          pa_q[gs] <= '0;
        end
        else if (k_run)
        begin
          pv_q[gs] <= pv_q[gs-1];
          pr_q[gs] <= pr_q[gs-1];
          pa_q[gs] <= pa_q[gs-1];
        end
      end
    end
  endgenerate

  // ===========================================================================
  // beat selection: which read beat launches and which write beat is captured
  logic              rd_hit;     // a read beat launches this edge
  logic [BW-1:0]     rd_beat;    // its position in the burst
  logic [ADDR_W-1:0] rd_base;    // its loaded address
  logic              wr_hit;     // a write beat is captured this edge
  logic [BW-1:0]     wr_beat;
  logic [ADDR_W-1:0] wr_base;

  // at most one read and one write stage can be active thanks to load spacing
  always_comb
  begin
    rd_hit  = 1'b0;
    rd_beat = '0;
    rd_base = '0;
    wr_hit  = 1'b0;
    wr_beat = '0;
    wr_base = '0;
    for (int i = 0; i < ddrp_pkg::BURST; i++)
    begin
      if (pv_q[RS0+i] && pr_q[RS0+i])                   // R6 R11
      begin
        rd_hit  = 1'b1;
        rd_beat = BW'(i);
        rd_base = pa_q[RS0+i];
      end
      if (pv_q[WS0+i] && !pr_q[WS0+i])                  // R7 R11
      begin
        wr_hit  = 1'b1;
        wr_beat = BW'(i);
        wr_base = pa_q[WS0+i];
      end
    end
  end

  // linear burst count in the two low bits only, upper bits untouched
  logic [ADDR_W-1:0] rd_addr;    // address of launching read beat
  logic [ADDR_W-1:0] wr_addr;    // address of captured write beat
  logic [BW-1:0]     burst_addr_rd;
  logic [BW-1:0]     burst_addr_wr;

  assign burst_addr_rd = rd_base[BW-1:0] + rd_beat;     // R1 R2
  assign burst_addr_wr = wr_base[BW-1:0] + wr_beat;     // R1 R2
  assign rd_addr       = {rd_base[ADDR_W-1:BW], burst_addr_rd};
  assign wr_addr       = {wr_base[ADDR_W-1:BW], burst_addr_wr};

  // ===========================================================================
  // write queue: captured beats wait here until the array port is free
  logic [NL-1:0] lane_en;        // lanes to be written by this beat
  logic          wq_in_valid;
  logic          wq_in_ready;
  logic          wq_out_valid;
  logic          wq_out_ready;
  logic [QW-1:0] wq_out_data;
  logic          out_adv;        // clock that times the read outputs is running

  assign lane_en     = {~lane1_write_sel_n, ~lane0_write_sel_n};    // R8
  // both selects high aborts the beat: nothing is queued
  assign wq_in_valid = k_run && wr_hit && (lane_en != '0);          // R8
  assign out_adv     = single_clk_mode ? k_run : oclk_run;          // R10
  // reads own the array port; queued writes wait while a read beat launches
  assign wq_out_ready = !(out_adv && rd_hit);

  ddrp_fifo #(
    .WIDTH (QW),
    .DEPTH (WQ_DEPTH)
  ) u_wq (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (wq_in_valid),
    .in_ready  (wq_in_ready),
    .in_data   ({wr_addr, dq_i, lane_en}),
    .out_valid (wq_out_valid),
    .out_ready (wq_out_ready),
    .out_data  (wq_out_data)
  );

  // ===========================================================================
  // storage, one array per byte lane so each array has a single writer
  wire  [DW-1:0] rd_word;        // array word at the launching read address
  logic          wq_pop;
  logic [ADDR_W-1:0] wq_addr;
  logic [DW-1:0]     wq_data;
  logic [NL-1:0]     wq_lanes;

  assign wq_pop   = wq_out_valid && wq_out_ready;
  assign wq_addr  = wq_out_data[QW-1 -: ADDR_W];
  assign wq_data  = wq_out_data[NL +: DW];
  assign wq_lanes = wq_out_data[NL-1:0];

  genvar gl;
  generate
    for (gl = 0; gl < NL; gl++)
    begin : g_lane
      // lane gl covers bits gl*9 up to gl*9+8
      logic [LW-1:0] lane_q [1 << ADDR_W];   // this lane's bits of every word

      // lane write; a shared array would have two writers with a moving index
      always_ff @(posedge clk_sys)
      begin
        if (wq_pop && wq_lanes[gl])                     // R8
          lane_q[wq_addr] <= wq_data[gl*LW +: LW];
      end

      // read side of this lane
      assign rd_word[gl*LW +: LW] = lane_q[rd_addr];
    end
  endgenerate

  // ===========================================================================
  // read output and bus release; the pins hold while the output clock stands
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      dq_o  <= ddrp_pkg::DQ_RST;
      dq_oe <= 1'b0;
    end
    else if (out_adv)                                   // R9 R10
    begin
      dq_oe <= rd_hit;                                  // R4 R6
      if (rd_hit)
        dq_o <= rd_word;                                // R6
    end
  end

  // ===========================================================================
  // status: phase seen by the master, and a pulse when a beat found the queue full
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      k_phase <= ddrp_pkg::PHASE_RISE;
      wr_drop <= 1'b0;
    end
    else
    begin
      k_phase <= k_run ? ~phase_q : phase_q;
      wr_drop <= wq_in_valid && !wq_in_ready;
    end
  end

endmodule

// File: verif/ddrp_master_model.sv
// ddrp_master_model: bus master issuing bursts to ddrp_port.
// assumes k_phase reports the phase of the next clk_sys edge.
`timescale 1ns/1ps
module ddrp_master_model #(
  parameter int ADDR_W = 6
) (
  // clock and phase
  input  wire logic                        clk_sys,
  input  wire logic                        k_phase,
  // command and lanes
  output logic                             load_select_n,
  output logic                             rw_sel,
  output logic [ADDR_W-1:0]                addr,
  output logic                             lane0_write_sel_n,
  output logic                             lane1_write_sel_n,
  // data
  output logic [ddrp_pkg::DATA_W-1:0]      dq_i,
  input  wire logic [ddrp_pkg::DATA_W-1:0] dq_o
);
  // idle bus; data never floats to a value it held
  initial
  begin
    load_select_n = 1'b1;
    rw_sel = 1'b0;
    addr = '0;
    lane0_write_sel_n = 1'b1;
    lane1_write_sel_n = 1'b1;
    dq_i = 18'h2aaaa;
  end
  // ==========
  // command slot; slot picks the phase of edge t (1 is a stray)
  task automatic cmd(input logic rd, input logic [ADDR_W-1:0] a, input logic slot,
                     output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 8 && !ok; n++)
    begin
      @(negedge clk_sys);
      ok = (k_phase === !slot);
    end
    @(posedge clk_sys);
    load_select_n <= 1'b0;
    rw_sel <= rd;
    addr <= a;
    @(posedge clk_sys);
    load_select_n <= 1'b1;
    rw_sel <= ~rd; // don't-care now, keep it moving
  endtask
  // read: beats sampled once settled after t+3..t+6 edges
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [17:0] d [4], output bit ok);
    cmd(1'b1, a, 1'b0, ok);
    repeat (3) @(posedge clk_sys);
    for (int b = 0; b < 4; b++)
    begin
      @(negedge clk_sys);
      d[b] = dq_o;
      if (b < 3)
        @(posedge clk_sys);
    end
  endtask
  // write: whole burst spent before returning, so spacing holds
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [17:0] d [4],
                    input logic [1:0] ln [4], output bit ok);
    cmd(1'b0, a, 1'b0, ok);
    repeat (7) @(posedge clk_sys);
    for (int b = 0; b < 4; b++)
    begin
      dq_i <= d[b];
      {lane1_write_sel_n, lane0_write_sel_n} <= ln[b];
      @(posedge clk_sys);
    end
    dq_i <= ~d[3];
    {lane1_write_sel_n, lane0_write_sel_n} <= 2'b11;
  endtask
endmodule

// File: verif/ddrp_port_bench.sv
// ddrp_port_bench: self-checking bench for ddrp_port.
// assumes the master model and the bound monitor.
`timescale 1ns/1ps
module ddrp_port_bench;
  localparam int AW = 6; // small array keeps runs short
  logic          clk_sys = 1'b0;
  logic          reset = 1'b1;
  logic          k_run = 1'b1;
  logic          oclk_run = 1'b1;
  logic          single_clk_mode = 1'b0;
  wire           load_select_n, rw_sel, lane0_write_sel_n, lane1_write_sel_n;
  wire [AW-1:0]  addr;
  wire [17:0]    dq_i, dq_o;
  wire           dq_oe, k_phase, wr_drop;
  logic [17:0]   mem [64]; // expected array contents
  int            err_count = 0;
  int            checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  ddrp_port #(.ADDR_W(AW)) u_dut (.clk_sys, .reset, .k_run, .oclk_run, .single_clk_mode,
    .load_select_n, .rw_sel, .addr, .lane0_write_sel_n, .lane1_write_sel_n, .dq_i, .dq_o,
    .dq_oe, .k_phase, .wr_drop);
  ddrp_master_model #(.ADDR_W(AW)) u_mst (.clk_sys, .k_phase, .load_select_n, .rw_sel,
    .addr, .lane0_write_sel_n, .lane1_write_sel_n, .dq_i, .dq_o);
  // ==========
  // helpers
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  // a slot never found counts an error and ends the run
  task automatic okay(input bit ok);
    if (!ok)
    begin
      err_count++;
      summarize();
    end
  endtask
  function automatic logic [AW-1:0] ba(input logic [AW-1:0] a, input int b);
    return {a[AW-1:2], a[1:0] + 2'(b)};
  endfunction
  task automatic do_wr(input logic [AW-1:0] a, input logic [17:0] d [4],
                       input logic [1:0] ln [4]);
    bit ok;
    u_mst.wr(a, d, ln, ok);
    okay(ok);
    for (int b = 0; b < 4; b++)
    begin
      if (!ln[b][0]) mem[ba(a, b)][8:0] = d[b][8:0];
      if (!ln[b][1]) mem[ba(a, b)][17:9] = d[b][17:9];
    end
  endtask
  task automatic do_rd(input logic [AW-1:0] a);
    logic [17:0] d [4];
    bit          ok;
    u_mst.rd(a, d, ok);
    okay(ok);
    for (int b = 0; b < 4; b++)
      chk(d[b], mem[ba(a, b)]);
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    @(negedge clk_sys);
    chk(18'({dq_oe, k_phase, wr_drop}), 18'h0);
  endtask
  // every start offset wraps modulo four
  task automatic t_burst();
    do_wr(6'h08, '{18'h11111, 18'h22222, 18'h33333, 18'h04444}, '{4{2'b00}});
    for (int s = 1; s < 4; s++)
      do_rd(6'(8 + s));
    do_wr(6'h13, '{18'h0a0a0, 18'h0b0b0, 18'h0c0c0, 18'h0d0d0}, '{4{2'b00}});
    do_rd(6'h10);
  endtask
  task automatic t_lanes();
    do_wr(6'h20, '{4{18'h00000}}, '{4{2'b00}});
    do_wr(6'h20, '{4{18'h3ffff}}, '{2'b10, 2'b01, 2'b00, 2'b11});
    do_rd(6'h20);
  endtask
  // load at a k# slot must stay idle
  task automatic t_stray();
    bit ok;
    u_mst.cmd(1'b1, 6'h08, 1'b1, ok);
    okay(ok);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_sys);
      chk(18'(dq_oe), 18'h0);
    end
  endtask
  task automatic t_stop();
    logic ph;
    @(posedge clk_sys);
    k_run <= 1'b0;
    @(negedge clk_sys);
    ph = k_phase;
    repeat (6) @(negedge clk_sys);
    chk(18'({dq_oe, k_phase}), 18'({1'b0, ph}));
    @(posedge clk_sys);
    k_run <= 1'b1;
    do_rd(6'h20);
  endtask
  // output clocks stopped outside single clock mode: no read beat may leave
  task automatic t_oclk_off();
    bit ok;
    @(posedge clk_sys);
    oclk_run <= 1'b0;
    u_mst.cmd(1'b1, 6'h08, 1'b0, ok);
    okay(ok);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_sys);
      chk(18'(dq_oe), 18'h0);
    end
  endtask
  task automatic t_single();
    @(posedge clk_sys);
    single_clk_mode <= 1'b1;
    oclk_run <= 1'b0;
    do_rd(6'h08);
    @(posedge clk_sys);
    single_clk_mode <= 1'b0;
    oclk_run <= 1'b1;
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_burst();
    t_lanes();
    t_stray();
    t_stop();
    t_oclk_off();
    t_single();
    summarize();
  end
endmodule

// File: verif/ddrp_port_monitor.sv
// ddrp_port_monitor: port-level checks of ddrp_port.
// assumes one clock, clk_sys, and the active-high async reset.
`timescale 1ns/1ps
module ddrp_port_monitor (
  // clock and reset
  input wire logic                        clk_sys,
  input wire logic                        reset,
  // clock status and command
  input wire logic                        k_run,
  input wire logic                        oclk_run,
  input wire logic                        single_clk_mode,
  input wire logic                        load_select_n,
  input wire logic                        rw_sel,
  // outputs under watch
  input wire logic [ddrp_pkg::DATA_W-1:0] dq_o,
  input wire logic                        dq_oe,
  input wire logic                        k_phase,
  input wire logic                        wr_drop
);
  // ==========
  // commands
  // taken only at a running k-rise slot
  wire rd_take = k_run && !k_phase && !load_select_n && rw_sel;
  wire wr_take = k_run && !k_phase && !load_select_n && !rw_sel;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // ==========
  // checks
  a_reset_quiet: assert property ($fell(reset) |-> !dq_oe && !k_phase && !wr_drop)
    else $error("outputs not idle after reset");
  a_phase_alt: assert property (k_run |=> k_phase != $past(k_phase))
    else $error("phase did not alternate");
  a_stop_holds: assert property (!k_run |=> $stable(dq_o) && $stable(dq_oe) && $stable(k_phase))
    else $error("pins moved while clock stopped");
  a_read_beats: assert property (rd_take && (single_clk_mode || oclk_run) |-> ##4 dq_oe [*4])
    else $error("read beats not driven at t+1.5 to t+3.0");
  a_read_end: assert property (rd_take ##4 !rd_take |-> ##4 !dq_oe)
    else $error("bus held after last read beat");
  a_oe_cause: assert property (dq_oe |->
    $past(rd_take, 4) || $past(rd_take, 5) || $past(rd_take, 6) || $past(rd_take, 7))
    else $error("bus driven without a taken read");
  a_write_quiet: assert property (wr_take |-> ##8 !dq_oe [*4])
    else $error("bus driven during write beats");
  a_single_clk: assert property (rd_take && single_clk_mode && !oclk_run |-> ##4 dq_oe)
    else $error("single clock read not launched");
  // spaced bursts never fill the write queue, so no beat may be lost
  a_drop_quiet: assert property (!wr_drop)
    else $error("write beat lost on a full queue");
endmodule
bind ddrp_port ddrp_port_monitor u_mon (.clk_sys, .reset, .k_run, .oclk_run, .single_clk_mode,
  .load_select_n, .rw_sel, .dq_o, .dq_oe, .k_phase, .wr_drop);
